// ==== sysclk_regs.vh ====
`ifndef SYSCLK_REGS_VH
`define SYSCLK_REGS_VH
// Behaviour
// - after any reset the internal high-frequency oscillator clocks the system.
// - software trims the high-frequency period via calibration; factory value gives 24.5 MHz.
// - system clock is high-frequency output divided by 1, 2, 4 or 8.
// - after reset the high-frequency post-divider select gives divide by 8.
// - system clock source: external, high-frequency, low-frequency or loop output.
// - software bits turn the high-frequency oscillator on and off.
// - low-frequency control register enables and calibrates that oscillator.
// - each internal oscillator has its own software-selected post-scaler.
// - loop multiplies by the 8-bit field; zero means 256.
// - upper two bits of loop filter register read zero, writes ignored.

// register addresses
`define SYSCLK_ADDR_HF_CTRL    8'hb2
`define SYSCLK_ADDR_HF_CAL     8'hb3
`define SYSCLK_ADDR_LF_CTRL    8'hb4
`define SYSCLK_ADDR_CLK_SEL    8'hb5
`define SYSCLK_ADDR_PLL_MUL    8'hb1
`define SYSCLK_ADDR_PLL_FLT    8'hb6
`define SYSCLK_ADDR_PLL_CTRL   8'hb7

// reset values
`define SYSCLK_RST_HF_CTRL     8'h83
`define SYSCLK_RST_HF_CAL      8'h40
`define SYSCLK_RST_LF_CTRL     8'h20
`define SYSCLK_RST_CLK_SEL     8'h00
`define SYSCLK_RST_PLL_MUL     8'h01
`define SYSCLK_RST_PLL_FLT     8'h31
`define SYSCLK_RST_PLL_CTRL    8'h00

// field positions
`define SYSCLK_HF_EN_BIT       7
`define SYSCLK_HF_DIV_LSB      0
`define SYSCLK_LF_EN_BIT       7
`define SYSCLK_LF_DIV_LSB      5
`define SYSCLK_LF_CAL_MSB      3
`define SYSCLK_SEL_LSB         0
`define SYSCLK_PLL_EN_BIT      0
`define SYSCLK_PLL_FLT_MASK    8'h3f

// source encodings
`define SYSCLK_SRC_HF          2'h0
`define SYSCLK_SRC_EXT         2'h1
`define SYSCLK_SRC_LF          2'h2
`define SYSCLK_SRC_PLL         2'h3
`endif

// ==== sysclk_postdiv.v ====
`timescale 1ns/10ps
// power-of-two post-scaler: divide by 1, 2, 4 or 8, one-cycle tick out
module sysclk_postdiv (
    input  wire       i_sys_clk,
    input  wire       i_sys_rst,
    input  wire       i_src_tick,
    input  wire [1:0] i_div_sel,
    output reg        o_tick
);
    reg [2:0] cnt_r;
    wire [2:0] mask = (3'h1 << i_div_sel) - 3'h1;

    // tick passes when the low counter bits wrap
    always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_r  <= 3'h0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= 1'b0;
            if (i_src_tick) begin
                if ((cnt_r & mask) == mask) begin
                    cnt_r  <= 3'h0;
                    o_tick <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 3'h1;
                end
            end
        end
    end
endmodule // sysclk_postdiv

// ==== sysclk_gen.v ====
`timescale 1ns/10ps
`include "sysclk_regs.vh"
// register file and source mux; oscillators arrive as enable ticks on i_sys_clk
module sysclk_gen (
    input  wire       i_sys_clk,
    input  wire       i_sys_rst,
    input  wire       i_sfr_wr,
    input  wire       i_sfr_rd,
    input  wire [7:0] i_sfr_addr,
    input  wire [7:0] i_sfr_wdata,
    output reg  [7:0] o_sfr_rdata,
    input  wire       i_hf_osc_tick,
    input  wire       i_lf_osc_tick,
    input  wire       i_ext_osc_tick,
    input  wire       i_pll_tick,
    output reg        o_sysclk_tick,
    output reg  [1:0] o_clk_source,
    output wire       o_hf_osc_en,
    output wire [7:0] o_hf_osc_trim,
    output wire       o_lf_osc_en,
    output wire [3:0] o_lf_osc_trim,
    output wire       o_pll_en,
    output reg  [8:0] o_pll_mult,
    output wire [1:0] o_pll_osc_range,
    output wire [3:0] o_pll_loop_filter
);
    reg [7:0] hf_osc_control_r;
    reg [7:0] hf_osc_calibration_r;
    reg [7:0] lf_osc_control_r;
    reg [7:0] clk_sel_r;
    reg [7:0] pll_multiplier_r;
    reg [7:0] pll_filter_config_r;
    reg [7:0] pll_ctrl_r;
    reg [7:0] rdata_nxt;
    wire      hf_div_tick;
    wire      lf_div_tick;
    wire [1:0] hf_postdiv_select = hf_osc_control_r[`SYSCLK_HF_DIV_LSB+1:`SYSCLK_HF_DIV_LSB];
    wire [1:0] lf_postdiv_select = lf_osc_control_r[`SYSCLK_LF_DIV_LSB+1:`SYSCLK_LF_DIV_LSB];
    wire [1:0] sel_field         = clk_sel_r[`SYSCLK_SEL_LSB+1:`SYSCLK_SEL_LSB];

    // register writes; reset restores hf source and divide by 8
    always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hf_osc_control_r     <= `SYSCLK_RST_HF_CTRL;
            hf_osc_calibration_r <= `SYSCLK_RST_HF_CAL;
            lf_osc_control_r     <= `SYSCLK_RST_LF_CTRL;
            clk_sel_r            <= `SYSCLK_RST_CLK_SEL;
            pll_multiplier_r     <= `SYSCLK_RST_PLL_MUL;
            pll_filter_config_r  <= `SYSCLK_RST_PLL_FLT;
            pll_ctrl_r           <= `SYSCLK_RST_PLL_CTRL;
        end else if (i_sfr_wr) begin
            case (i_sfr_addr)
                `SYSCLK_ADDR_HF_CTRL:  hf_osc_control_r     <= i_sfr_wdata & 8'h83;
                `SYSCLK_ADDR_HF_CAL:   hf_osc_calibration_r <= i_sfr_wdata;
                `SYSCLK_ADDR_LF_CTRL:  lf_osc_control_r     <= i_sfr_wdata & 8'hef;
                `SYSCLK_ADDR_CLK_SEL:  clk_sel_r            <= i_sfr_wdata & 8'h03;
                `SYSCLK_ADDR_PLL_MUL:  pll_multiplier_r     <= i_sfr_wdata;
                `SYSCLK_ADDR_PLL_FLT:  pll_filter_config_r  <= i_sfr_wdata & `SYSCLK_PLL_FLT_MASK;
                `SYSCLK_ADDR_PLL_CTRL: pll_ctrl_r           <= i_sfr_wdata & 8'h01;
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        case (i_sfr_addr)
            `SYSCLK_ADDR_HF_CTRL:  rdata_nxt = hf_osc_control_r;
            `SYSCLK_ADDR_HF_CAL:   rdata_nxt = hf_osc_calibration_r;
            `SYSCLK_ADDR_LF_CTRL:  rdata_nxt = lf_osc_control_r;
            `SYSCLK_ADDR_CLK_SEL:  rdata_nxt = clk_sel_r;
            `SYSCLK_ADDR_PLL_MUL:  rdata_nxt = pll_multiplier_r;
            `SYSCLK_ADDR_PLL_FLT:  rdata_nxt = pll_filter_config_r & `SYSCLK_PLL_FLT_MASK;
            `SYSCLK_ADDR_PLL_CTRL: rdata_nxt = pll_ctrl_r;
            default:               rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            o_sfr_rdata <= 8'h00;
        else if (i_sfr_rd)
            o_sfr_rdata <= rdata_nxt;
    end

    // separate post-scalers per internal oscillator
    sysclk_postdiv u_hf_div (
        .i_sys_clk  (i_sys_clk),
        .i_sys_rst  (i_sys_rst),
        .i_src_tick (i_hf_osc_tick & o_hf_osc_en),
        .i_div_sel  (hf_postdiv_select),
        .o_tick     (hf_div_tick)
    );
    sysclk_postdiv u_lf_div (
        .i_sys_clk  (i_sys_clk),
        .i_sys_rst  (i_sys_rst),
        .i_src_tick (i_lf_osc_tick & o_lf_osc_en),
        .i_div_sel  (lf_postdiv_select),
        .o_tick     (lf_div_tick)
    );

    // source mux, registered so the tick is glitch-free
    always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_sysclk_tick <= 1'b0;
            o_clk_source  <= `SYSCLK_SRC_HF;
            o_pll_mult    <= 9'h001;
        end else begin
            o_clk_source <= sel_field;
            case (sel_field)
                `SYSCLK_SRC_HF:  o_sysclk_tick <= hf_div_tick;
                `SYSCLK_SRC_EXT: o_sysclk_tick <= i_ext_osc_tick;
                `SYSCLK_SRC_LF:  o_sysclk_tick <= lf_div_tick;
                `SYSCLK_SRC_PLL: o_sysclk_tick <= i_pll_tick & o_pll_en;
                default:         o_sysclk_tick <= 1'b0;
            endcase
            // zero multiplier field means 256
            o_pll_mult <= (pll_multiplier_r == 8'h00) ? 9'h100 : {1'b0, pll_multiplier_r};
        end
    end

    assign o_hf_osc_en       = hf_osc_control_r[`SYSCLK_HF_EN_BIT];
    assign o_hf_osc_trim     = hf_osc_calibration_r;
    assign o_lf_osc_en       = lf_osc_control_r[`SYSCLK_LF_EN_BIT];
    assign o_lf_osc_trim     = lf_osc_control_r[`SYSCLK_LF_CAL_MSB:0];
    assign o_pll_en          = pll_ctrl_r[`SYSCLK_PLL_EN_BIT];
    // software owns range and filter choice; hardware only forwards them
    assign o_pll_osc_range   = pll_filter_config_r[5:4];
    assign o_pll_loop_filter = pll_filter_config_r[3:0];
endmodule // sysclk_gen

// ==== sysclk_gen_properties.sv ====
`timescale 1ns/10ps
`include "sysclk_regs.vh"
module sysclk_gen_checker (
    input wire       i_sys_clk,
    input wire       i_sys_rst,
    input wire       i_sfr_wr,
    input wire       i_sfr_rd,
    input wire [7:0] i_sfr_addr,
    input wire [7:0] i_sfr_wdata,
    input wire [7:0] o_sfr_rdata,
    input wire       o_sysclk_tick,
    input wire [1:0] o_clk_source,
    input wire       o_hf_osc_en,
    input wire [7:0] o_hf_osc_trim,
    input wire       o_lf_osc_en,
    input wire [3:0] o_lf_osc_trim,
    input wire [8:0] o_pll_mult
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // write decodes; register outputs follow one edge after the write, source and multiplier two edges
    wire wr_hf  = i_sfr_wr && i_sfr_addr == `SYSCLK_ADDR_HF_CTRL;
    wire wr_cal = i_sfr_wr && i_sfr_addr == `SYSCLK_ADDR_HF_CAL;
    wire wr_lf  = i_sfr_wr && i_sfr_addr == `SYSCLK_ADDR_LF_CTRL;
    wire wr_sel = i_sfr_wr && i_sfr_addr == `SYSCLK_ADDR_CLK_SEL;
    wire wr_mul = i_sfr_wr && i_sfr_addr == `SYSCLK_ADDR_PLL_MUL;
    a_reset_hf_source: assert property ($fell(i_sys_rst) |-> o_clk_source == `SYSCLK_SRC_HF)
        else $error("source not hf after reset");
    a_hf_trim_follows: assert property (wr_cal |=> o_hf_osc_trim == $past(i_sfr_wdata))
        else $error("hf trim not written");
    a_source_follows: assert property (wr_sel |-> ##2 {6'h00, o_clk_source} == ($past(i_sfr_wdata, 2) & 8'h03))
        else $error("source not selected");
    a_hf_enable_follows: assert property (wr_hf |=> {o_hf_osc_en, 7'h00} == ($past(i_sfr_wdata) & 8'h80))
        else $error("hf enable wrong");
    a_lf_ctrl_follows: assert property (wr_lf |=> {o_lf_osc_en, 3'h0, o_lf_osc_trim} == ($past(i_sfr_wdata) & 8'h8f))
        else $error("lf control wrong");
    a_mult_zero_full: assert property (wr_mul && i_sfr_wdata == 8'h00 |-> ##2 o_pll_mult == 9'h100)
        else $error("zero multiplier not 256");
    a_mult_value_kept: assert property (wr_mul && i_sfr_wdata != 8'h00 |-> ##2 o_pll_mult == {1'b0, $past(i_sfr_wdata, 2)})
        else $error("multiplier wrong");
    a_filter_top_zero: assert property (i_sfr_rd && i_sfr_addr == `SYSCLK_ADDR_PLL_FLT |=> o_sfr_rdata[7:6] == 2'b00)
        else $error("filter top bits set");
    c_lf_tick: cover property (o_sysclk_tick && o_clk_source == `SYSCLK_SRC_LF);
    c_pll_tick: cover property (o_sysclk_tick && o_clk_source == `SYSCLK_SRC_PLL);
    c_mult_full: cover property (o_pll_mult == 9'h100);
endmodule // sysclk_gen_checker
bind sysclk_gen sysclk_gen_checker sysclk_gen_checker_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .o_sysclk_tick(o_sysclk_tick), .o_clk_source(o_clk_source),
    .o_hf_osc_en(o_hf_osc_en), .o_hf_osc_trim(o_hf_osc_trim), .o_lf_osc_en(o_lf_osc_en),
    .o_lf_osc_trim(o_lf_osc_trim), .o_pll_mult(o_pll_mult));

// ==== test_sysclk_gen.sv ====
`timescale 1ns/10ps
`include "sysclk_regs.vh"
module test_sysclk_gen;
    reg        i_sys_clk = 1'b0;
    reg        i_sys_rst = 1'b1;
    reg        wr = 1'b0, rd = 1'b0;
    reg  [7:0] addr = 8'h00, wdata = 8'h00;
    reg  [3:0] osc = 4'h0; // one tick per source, indexed by source code
    wire [7:0] rdata, trim;
    wire [1:0] src, rng;
    wire [3:0] lf_trim, flt;
    wire [8:0] mult;
    wire       tick, hf_en, lf_en, pll_en;
    integer    n_mismatch = 0, samples_checked = 0, i;
    sysclk_gen sysclk_gen_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_sfr_wr(wr), .i_sfr_rd(rd),
        .i_sfr_addr(addr), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_hf_osc_tick(osc[0]),
        .i_ext_osc_tick(osc[1]), .i_lf_osc_tick(osc[2]), .i_pll_tick(osc[3]), .o_sysclk_tick(tick),
        .o_clk_source(src), .o_hf_osc_en(hf_en), .o_hf_osc_trim(trim), .o_lf_osc_en(lf_en),
        .o_lf_osc_trim(lf_trim), .o_pll_en(pll_en), .o_pll_mult(mult), .o_pll_osc_range(rng),
        .o_pll_loop_filter(flt));
    // 200 MHz system clock
    always #2.5 i_sys_clk = ~i_sys_clk;
    // one register access: write if w, else read; strobe held for one edge
    task acc(input w, input [7:0] a, input [7:0] d);
        begin
            @(posedge i_sys_clk) #1;
            {wr, rd, addr, wdata} = {w, ~w, a, d};
            @(posedge i_sys_clk) #1;
            {wr, rd} = 2'b00;
        end
    endtask
    task check(input [8:0] got, input [8:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // 64 source ticks, a multiple of every divider, so divider phase cannot skew the count
    task count(input [1:0] s, input [8:0] exp);
        integer k, n;
        begin
            n = 0;
            for (k = 0; k < 72; k = k + 1) begin
                @(posedge i_sys_clk) #1;
                osc = (k < 64) ? (4'h1 << s) : 4'h0;
                if (tick === 1'b1) n = n + 1;
            end
            check(n[8:0], exp);
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    // run is about 800 cycles; cut a hang well beyond that
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        results;
    end
    initial begin
        for (i = 0; i < 2; i = i + 1) begin
            i_sys_rst = 1'b1;
            repeat (16) @(posedge i_sys_clk);
            #1 i_sys_rst = 1'b0;
            check({7'h00, src}, 9'h000);
            count(2'h0, 9'd8);
            acc(1'b0, `SYSCLK_ADDR_PLL_FLT, 8'h00);
            check({1'b0, rdata}, 9'h031);
            acc(1'b1, `SYSCLK_ADDR_HF_CAL, 8'h5a);
        end
        $display("reset defaults done");
        check({1'b0, trim}, 9'h05a);
        for (i = 0; i < 4; i = i + 1) begin
            acc(1'b1, `SYSCLK_ADDR_HF_CTRL, 8'h80 | i[7:0]);
            count(2'h0, 9'd64 >> i);
        end
        acc(1'b1, `SYSCLK_ADDR_HF_CTRL, 8'h03);
        check({8'h00, hf_en}, 9'h000);
        acc(1'b1, `SYSCLK_ADDR_HF_CTRL, 8'h83);
        acc(1'b1, `SYSCLK_ADDR_LF_CTRL, 8'hcf);
        check({4'h0, lf_en, lf_trim}, 9'h01f);
        acc(1'b1, `SYSCLK_ADDR_PLL_CTRL, 8'h01);
        check({8'h00, pll_en}, 9'h001);
        for (i = 0; i < 4; i = i + 1) begin
            acc(1'b1, `SYSCLK_ADDR_CLK_SEL, i[7:0]);
            // source output is registered behind the select register
            @(posedge i_sys_clk) #1;
            check({7'h00, src}, i[8:0]);
            count(i[1:0], (i == 0) ? 9'd8 : (i == 2) ? 9'd16 : 9'd64);
        end
        $display("source and divider done");
        acc(1'b1, `SYSCLK_ADDR_PLL_MUL, 8'h00);
        @(posedge i_sys_clk) #1;
        check(mult, 9'h100);
        acc(1'b1, `SYSCLK_ADDR_PLL_MUL, 8'h7f);
        @(posedge i_sys_clk) #1;
        check(mult, 9'h07f);
        // legal range 10 and filter 0011, with the unused top bits set
        acc(1'b1, `SYSCLK_ADDR_PLL_FLT, 8'he3);
        acc(1'b0, `SYSCLK_ADDR_PLL_FLT, 8'h00);
        check({1'b0, rdata}, 9'h023);
        check({3'h0, rng, flt}, 9'h023);
        acc(1'b0, 8'hc0, 8'h00);
        check({1'b0, rdata}, 9'h000);
        $display("loop registers done");
        results;
    end
endmodule // test_sysclk_gen
